// >>> bench/rsf_client_model.sv
`timescale 1ns/1ns
`default_nettype none
module rsf_client_model (
	// stream from the framer
	input wire logic i_mclk, i_arst_n, i_valid, i_last, i_err,
	// acceptance and count of kept packets
	output logic o_ready,
	output int o_kept
);
	logic [2:0] cnt_r;
	logic bad_r;
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_r <= 3'h0;
			bad_r <= 1'b0;
			o_ready <= 1'b0;
			o_kept <= 0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			// runs of five accepts, then three stalls
			o_ready <= cnt_r < 3'h5;
			if (i_valid && o_ready) begin
				bad_r <= i_last ? 1'b0 : bad_r | i_err;
				if (i_last && !(bad_r | i_err)) o_kept <= o_kept + 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/rsf_framer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rsf_framer_properties
	import rsf_pkg::*;
#(parameter int DATA_W = 256) (
	// watched ports
	input wire logic i_mclk, i_arst_n, i_ce, i_ready, o_beat_ready,
	input wire rsf_beat_type i_beat,
	input wire logic o_request_beat_valid, o_request_beat_last, o_aer_report,
	input wire logic [DATA_W-1:0] o_request_data_bus,
	input wire logic [RSF_SB_W-1:0] o_request_sideband_bus
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	wire v = o_request_beat_valid;
	wire [RSF_SB_W-1:0] sb = o_request_sideband_bus;
	sequence take_s; i_ce && i_beat.valid && o_beat_ready; endsequence
	sequence stall_s; v && !i_ready; endsequence
	sop_take_a: assert property (take_s |=> v && sb[RSF_SOP_BIT] == $past(i_beat.first))
		else $error("sop");
	lane_force_a: assert property (take_s ##0 (i_beat.first && i_beat.kind[1]) |=> sb[7:4] == 4'hF)
		else $error("lane");
	stall_hold_a: assert property (stall_s |=> v && $stable(sb) && $stable(o_request_data_bus))
		else $error("hold");
	err_last_a: assert property (v && sb[RSF_ERR_BIT] |-> o_request_beat_last)
		else $error("err");
	par_byte_a: assert property (v |-> sb[RSF_PAR_LO] == ~^o_request_data_bus[7:0])
		else $error("par");
	upper_zero_a: assert property (((sb[RSF_PAR_HI:RSF_PAR_LO] | sb[RSF_BVALID_HI:RSF_BVALID_LO]) >> (DATA_W / 8)) == 0)
		else $error("upper");
	body_quiet_a: assert property (v && !sb[RSF_SOP_BIT] |-> sb[RSF_TAG_HI:RSF_HINT_BIT] == 0)
		else $error("hint");
	ready_eq_a: assert property (o_beat_ready == (i_ce && (!v || i_ready)))
		else $error("ready");
	aer_pulse_a: assert property (o_aer_report |-> v && sb[RSF_ERR_BIT] && o_request_beat_last)
		else $error("aer");
endmodule
bind rsf_framer rsf_framer_properties #(.DATA_W(DATA_W)) i_props (.i_mclk, .i_arst_n, .i_ce,
	.i_ready, .o_beat_ready, .i_beat, .o_request_beat_valid, .o_request_beat_last,
	.o_aer_report, .o_request_data_bus, .o_request_sideband_bus);
`default_nettype wire

// >>> bench/rsf_framer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rsf_framer_tb_top;
	import rsf_pkg::*;
	localparam int DW = 128;
	logic i_mclk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, rdy, o_beat_ready, o_irq, o_aer_report;
	logic o_request_beat_valid, o_request_beat_last;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata, seed = 32'hD37D786F, r;
	rsf_beat_type i_beat = '0, b;
	logic [DW-1:0] i_data = '0, o_request_data_bus, dd;
	logic [RSF_SB_W-1:0] o_request_sideband_bus, x;
	logic [RSF_SB_W+DW:0] q[$], y;
	int fail_count = 0, n_compared = 0, kept, good = 0, npkt = 0, err = 0, k, j, nb;
	initial forever #50 i_mclk = ~i_mclk;
	rsf_framer #(.DATA_W(DW)) i_rsf_framer (.i_mclk, .i_arst_n, .i_ce(1'b1), .i_beat, .i_data,
		.o_beat_ready, .o_request_data_bus, .o_request_sideband_bus, .o_request_beat_valid,
		.o_request_beat_last, .i_ready(rdy), .o_aer_report, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .o_irq);
	rsf_client_model i_rsf_client_model (.i_mclk, .i_arst_n, .i_valid(o_request_beat_valid),
		.i_last(o_request_beat_last), .i_err(o_request_sideband_bus[RSF_ERR_BIT]),
		.o_ready(rdy), .o_kept(kept));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(string n, logic [DW:0] s, e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// d is write data, or the expected read data
	task automatic reg_op(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		@(negedge i_mclk);
		if (!w) chk("rdata", o_rdata, d);
	endtask
	always @(posedge i_mclk) if (o_request_beat_valid === 1'b1 && rdy === 1'b1) begin
		y = q.pop_front();
		chk("sideband", o_request_sideband_bus, y[RSF_SB_W+DW-1:DW]);
		chk("data_last", {o_request_beat_last, o_request_data_bus}, {y[RSF_SB_W+DW], y[DW-1:0]});
	end
	initial begin
		repeat (3) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		reg_op(0, RSF_REG_MASK, RSF_MASK_RST);
		reg_op(0, RSF_REG_CTRL, RSF_CTRL_RST);
		reg_op(0, 4'hF, 32'h0);
		reg_op(1, RSF_REG_MASK, 32'h7);
		@(posedge i_mclk);
		repeat (40) begin
			r = rnd();
			nb = r[1:0] % 3 + 1;
			for (j = 0; j < nb; j++) begin
				b = '{1'b1, j == 0, j == nb - 1, rsf_kind_type'(r[3:2]), r[3:2] == 1 && nb == 1 && r[4],
					r[11:8], r[3:2] ? 32'h0000FFFF >> r[15:12] : 32'h0, r[16], r[16] ? r[18:17] : 2'h0,
					r[16] ? r[26:19] : 8'h0, r[5] & r[6] & !r[4]};
				dd = {rnd(), rnd(), rnd(), rnd()};
				i_beat <= b;
				i_data <= dd;
				x = '0;
				x[RSF_SOP_BIT] = b.first;
				if (b.first) x[RSF_TAG_HI:RSF_HINT_BIT] = {b.steering_tag, b.hint_type, b.hint_present};
				if (b.first) x[7:4] = b.kind[1] ? 4'hF : b.final_dword_lane_mask;
				x[39:8] = b.zero_len ? 32'h0 : b.payload_mask;
				x[RSF_ERR_BIT] = b.last && b.mem_error && b.kind != RSF_KIND_READ;
				for (k = 0; k < DW / 8; k++) x[RSF_PAR_LO + k] = ~^dd[8 * k +: 8];
				q.push_back({b.last, x, dd});
				err += x[RSF_ERR_BIT];
				good += b.last && !x[RSF_ERR_BIT];
				npkt += b.last;
				k = 0;
				do begin
					@(posedge i_mclk);
					k++;
				end while (o_beat_ready !== 1'b1 && k < 60);
				if (o_beat_ready !== 1'b1) begin
					fail_count++;
					report_and_stop();
				end
			end
		end
		i_beat <= '0;
		for (k = 0; k < 100 && q.size() > 0; k++) @(posedge i_mclk);
		chk("drained", q.size(), 0);
		chk("kept", kept, good);
		reg_op(0, RSF_REG_COUNT, npkt);
		reg_op(0, RSF_REG_STATUS, {1'b1, err > 0, err > 0});
		chk("irq_set", o_irq, 1'b1);
		reg_op(1, RSF_REG_MASK, 32'h0);
		@(negedge i_mclk);
		chk("irq_masked", o_irq, 1'b0);
		reg_op(1, RSF_REG_MASK, 32'h7);
		reg_op(1, RSF_REG_STATUS, 32'h7);
		@(negedge i_mclk);
		chk("irq_clear", o_irq, 1'b0);
		reg_op(0, RSF_REG_STATUS, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> rtl/rsf_framer.sv
// Overview of operation
// - final-Dword lane mask bits 7:4 follow header last byte enables.
// - atomics and data-carrying messages force the lane mask to all ones.
// - lane mask meaningful only when first-beat marker and valid are high.
// - bits 39:8 flag payload bytes of the data bus, never descriptor bytes.
// - payload over two Dwords gives a contiguous run of byte-valid bits.
// - zero-length write sends one Dword payload with all byte-valid bits zero.
// - 128-bit bus zeroes byte-valid 31:16; 64-bit bus zeroes 31:8.
// - first-beat marker bit 40 high in every packet's first beat.
// - payload-error never without payload, only in a last beat.
// - as endpoint, each payload error also reported upstream via error reporting.
// - hint-present bit 42 set when the request carries a processing hint.
// - hint PH value on bits 44:43 in the first beat.
// - hint steering tag on bits 52:45 in the first beat.
// - bits 84:53 hold odd parity of each data byte.
// - unused upper parity bits held at zero for narrow buses.
// - data bus width is 64, 128 or 256 bits.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module rsf_framer
	import rsf_pkg::*;
#(
	parameter int DATA_W = 256
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// beat from the core
	input wire rsf_beat_type i_beat,
	input wire logic [DATA_W-1:0] i_data,
	output logic o_beat_ready,
	// stream to the client
	output logic [DATA_W-1:0] o_request_data_bus,
	output logic [RSF_SB_W-1:0] o_request_sideband_bus,
	output logic o_request_beat_valid,
	output logic o_request_beat_last,
	input wire logic i_ready,
	// error reporting towards the upstream port
	output logic o_aer_report,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_irq
);

	localparam int NBYTES = DATA_W / 8;

	// everything that persists across cycles
	typedef struct packed {
		logic valid;
		logic last;
		logic [DATA_W-1:0] data;
		logic [RSF_SB_W-1:0] sb;
		logic has_payload;
		rsf_state_type st;
		rsf_regs_type regs;
	} rsf_state_all_type;

	rsf_state_all_type s_r;
	rsf_state_all_type s_nxt;

	// only the three supported widths elaborate
	if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256) begin : g_bad_width
		$error("rsf_framer data width must be 64, 128 or 256");
	end

	// beat acceptance
	logic take;
	logic accept;
	logic pkt_done;

	// per-lane results; lanes above the bus width stay zero
	logic [RSF_MAX_BYTES-1:0] bvalid;
	logic [RSF_MAX_BYTES-1:0] parity;

	// header-derived decisions
	logic [3:0] lane;
	logic has_pl;
	logic pkt_has_pl;
	logic err_flag;
	logic aer_set;

	// header fields, present only in a packet's first beat
	logic f_sop;
	logic [3:0] f_lane;
	logic f_hint;
	logic [1:0] f_ph;
	logic [7:0] f_tag;

	// sideband vector of the beat being taken
	logic [RSF_SB_W-1:0] sb_new;

	// next values of the output slot
	logic valid_new;
	logic last_new;
	logic [DATA_W-1:0] data_new;
	logic [RSF_SB_W-1:0] sb_slot;
	logic has_pl_new;
	rsf_state_type st_new;

	// register port
	logic [31:0] rd_word;
	logic [2:0] status_wr;
	logic [2:0] ev;
	logic [2:0] status_new;
	logic [15:0] count_new;
	logic [2:0] mask_new;
	logic endpoint_new;

	// output slot is free or drains this cycle; a stall holds the slot and packet state
	assign take = !s_r.valid || i_ready;
	assign o_beat_ready = take && i_ce;
	assign accept = take && i_beat.valid;
	assign pkt_done = accept && i_beat.last;

	// one lane per data byte
	for (genvar g = 0; g < RSF_MAX_BYTES; g++) begin : g_lane
		if (g < NBYTES) begin : g_used
			// zero-length write carries a dummy Dword with no valid byte
			assign bvalid[g] = i_beat.payload_mask[g] && !i_beat.zero_len;
			// xnor of the byte makes the total count of ones odd
			assign parity[g] = ~^i_data[g*8 +: 8];
		end else begin : g_unused
			assign bvalid[g] = 1'b0;
			assign parity[g] = 1'b0;
		end
	end

	// final-Dword lane mask from the header, forced for atomics and messages
	always_comb begin
		case (i_beat.kind)
			RSF_KIND_READ: begin
				lane = i_beat.final_dword_lane_mask;
			end
			RSF_KIND_WRITE: begin
				lane = i_beat.final_dword_lane_mask;
			end
			RSF_KIND_ATOMIC: begin
				lane = 4'hF;
			end
			RSF_KIND_MSGDATA: begin
				lane = 4'hF;
			end
			default: begin
				lane = i_beat.final_dword_lane_mask;
			end
		endcase
	end

	// reads carry no payload; a zero-length write still sends one Dword
	always_comb begin
		case (i_beat.kind)
			RSF_KIND_READ: begin
				has_pl = 1'b0;
			end
			RSF_KIND_WRITE: begin
				has_pl = 1'b1;
			end
			RSF_KIND_ATOMIC: begin
				has_pl = 1'b1;
			end
			RSF_KIND_MSGDATA: begin
				has_pl = 1'b1;
			end
			default: begin
				has_pl = 1'b0;
			end
		endcase
	end

	// later beats reuse what the first beat recorded
	assign pkt_has_pl = (s_r.st == RSF_ST_FIRST) ? has_pl : s_r.has_payload;

	// error flag only in the last beat of a payload-bearing packet
	always_comb begin
		err_flag = 1'b0;
		aer_set = 1'b0;
		if (accept && i_beat.last && i_beat.mem_error && pkt_has_pl) begin
			err_flag = 1'b1;
			// a root port has nobody upstream to tell
			aer_set = s_r.regs.endpoint;
		end
	end

	// header fields mean nothing outside the first beat
	always_comb begin
		f_sop = 1'b0;
		f_lane = 4'h0;
		f_hint = 1'b0;
		f_ph = 2'h0;
		f_tag = 8'h0;
		if (i_beat.first) begin
			f_sop = 1'b1;
			f_lane = lane;
			f_hint = i_beat.hint_present;
		end
		// type and tag stay zero without a hint
		if (i_beat.first && i_beat.hint_present) begin
			f_ph = i_beat.hint_type;
			f_tag = i_beat.steering_tag;
		end
	end

	// the source keeps a long payload's byte lanes contiguous
	always_comb begin
		sb_new = '0;
		sb_new[RSF_LANE_HI:RSF_LANE_LO] = f_lane;
		sb_new[RSF_BVALID_HI:RSF_BVALID_LO] = bvalid;
		sb_new[RSF_SOP_BIT] = f_sop;
		sb_new[RSF_ERR_BIT] = err_flag;
		sb_new[RSF_HINT_BIT] = f_hint;
		sb_new[RSF_PH_HI:RSF_PH_LO] = f_ph;
		sb_new[RSF_TAG_HI:RSF_TAG_LO] = f_tag;
		sb_new[RSF_PAR_HI:RSF_PAR_LO] = parity;
	end

	// output slot: a stalled beat keeps its data and sideband
	always_comb begin
		valid_new = s_r.valid;
		last_new = s_r.last;
		data_new = s_r.data;
		sb_slot = s_r.sb;
		if (s_r.valid && i_ready) begin
			valid_new = 1'b0;
		end
		if (accept) begin
			valid_new = 1'b1;
			last_new = i_beat.last;
			data_new = i_data;
			sb_slot = sb_new;
		end
	end

	// payload presence is latched at the first beat for the error decision
	assign has_pl_new = (accept && i_beat.first) ? has_pl : s_r.has_payload;

	// packet position, advanced by every accepted beat
	always_comb begin
		st_new = s_r.st;
		if (accept) begin
			case (s_r.st)
				RSF_ST_FIRST: begin
					st_new = i_beat.last ? RSF_ST_FIRST : RSF_ST_BODY;
				end
				RSF_ST_BODY: begin
					st_new = i_beat.last ? RSF_ST_FIRST : RSF_ST_BODY;
				end
				default: begin
					st_new = RSF_ST_FIRST;
				end
			endcase
		end
	end

	// status events: payload error, upstream report, packet done
	always_comb begin
		ev = 3'h0;
		ev[RSF_EV_ERR] = err_flag;
		ev[RSF_EV_AER] = aer_set;
		ev[RSF_EV_PKT] = pkt_done;
	end

	// packet counter wraps silently
	always_comb begin
		count_new = s_r.regs.count;
		if (pkt_done) begin
			count_new = s_r.regs.count + 16'h0001;
		end
	end

	// read decode; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0;
		if (i_rd) begin
			case (i_addr)
				RSF_REG_STATUS: begin
					rd_word = {29'h0, s_r.regs.status};
				end
				RSF_REG_MASK: begin
					rd_word = {29'h0, s_r.regs.mask};
				end
				RSF_REG_COUNT: begin
					rd_word = {16'h0, s_r.regs.count};
				end
				RSF_REG_CTRL: begin
					rd_word = {31'h0, s_r.regs.endpoint};
				end
				default: begin
					rd_word = 32'h0;
				end
			endcase
		end
	end

	// write-one-to-clear bits of the status register
	always_comb begin
		status_wr = 3'h0;
		if (i_wr && i_addr == RSF_REG_STATUS) begin
			status_wr = i_wdata[2:0];
		end
	end

	// a set in the same cycle as its clear wins, so no event is lost
	for (genvar e = 0; e < 3; e++) begin : g_status
		assign status_new[e] = ev[e] || (s_r.regs.status[e] && !status_wr[e]);
	end

	// control writes; other offsets leave both registers alone
	always_comb begin
		mask_new = s_r.regs.mask;
		endpoint_new = s_r.regs.endpoint;
		if (i_wr) begin
			case (i_addr)
				RSF_REG_MASK: begin
					mask_new = i_wdata[2:0];
				end
				RSF_REG_CTRL: begin
					endpoint_new = i_wdata[0];
				end
				default: begin
					mask_new = s_r.regs.mask;
				end
			endcase
		end
	end

	// single next-state process for all state
	always_comb begin
		s_nxt = s_r;
		s_nxt.valid = valid_new;
		s_nxt.last = last_new;
		s_nxt.data = data_new;
		s_nxt.sb = sb_slot;
		s_nxt.has_payload = has_pl_new;
		s_nxt.st = st_new;
		// upstream report is a one-cycle pulse
		s_nxt.regs.aer = aer_set;
		s_nxt.regs.status = status_new;
		s_nxt.regs.mask = mask_new;
		s_nxt.regs.count = count_new;
		s_nxt.regs.endpoint = endpoint_new;
		s_nxt.regs.rdata = rd_word;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '0;
			s_r.regs.mask <= RSF_MASK_RST;
			s_r.regs.endpoint <= RSF_CTRL_RST;
			s_r.st <= RSF_ST_FIRST;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_request_data_bus = s_r.data;
	assign o_request_sideband_bus = s_r.sb;
	assign o_request_beat_valid = s_r.valid;
	assign o_request_beat_last = s_r.last;
	assign o_aer_report = s_r.regs.aer;
	assign o_rdata = s_r.regs.rdata;
	// level interrupt follows the registered status and mask
	assign o_irq = |(s_r.regs.status & s_r.regs.mask);

endmodule
`default_nettype wire

// >>> rtl/rsf_pkg.sv
package rsf_pkg;

	// sideband field positions
	localparam int RSF_LANE_LO = 4;
	localparam int RSF_LANE_HI = 7;
	localparam int RSF_BVALID_LO = 8;
	localparam int RSF_BVALID_HI = 39;
	localparam int RSF_SOP_BIT = 40;
	localparam int RSF_ERR_BIT = 41;
	localparam int RSF_HINT_BIT = 42;
	localparam int RSF_PH_LO = 43;
	localparam int RSF_PH_HI = 44;
	localparam int RSF_TAG_LO = 45;
	localparam int RSF_TAG_HI = 52;
	localparam int RSF_PAR_LO = 53;
	localparam int RSF_PAR_HI = 84;
	localparam int RSF_SB_W = 85;
	localparam int RSF_MAX_BYTES = 32;

	// register map
	localparam logic [3:0] RSF_REG_STATUS = 4'h0;
	localparam logic [3:0] RSF_REG_MASK = 4'h1;
	localparam logic [3:0] RSF_REG_COUNT = 4'h2;
	localparam logic [3:0] RSF_REG_CTRL = 4'h3;
	localparam logic [2:0] RSF_MASK_RST = 3'h0;
	localparam logic [0:0] RSF_CTRL_RST = 1'h1;
	localparam int RSF_EV_ERR = 0;
	localparam int RSF_EV_AER = 1;
	localparam int RSF_EV_PKT = 2;

	// request kind of the packet being framed
	typedef enum logic [1:0] {
		RSF_KIND_READ = 2'b00,
		RSF_KIND_WRITE = 2'b01,
		RSF_KIND_ATOMIC = 2'b10,
		RSF_KIND_MSGDATA = 2'b11
	} rsf_kind_type;

	typedef enum logic [0:0] {
		RSF_ST_FIRST = 1'b0,
		RSF_ST_BODY = 1'b1
	} rsf_state_type;

	// per-beat input description from the core
	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		rsf_kind_type kind;
		logic zero_len;
		logic [3:0] final_dword_lane_mask;
		logic [31:0] payload_mask;
		logic hint_present;
		logic [1:0] hint_type;
		logic [7:0] steering_tag;
		logic mem_error;
	} rsf_beat_type;

	typedef struct packed {
		logic [2:0] status;
		logic [2:0] mask;
		logic [15:0] count;
		logic endpoint;
		logic [31:0] rdata;
		logic aer;
	} rsf_regs_type;

endpackage
